// >>> logic/eipe_regs.sv
// eipe_regs: extended interrupt priority register and second
// extended interrupt enable register, with their decoded bits.
// assumes the core's byte-wide special-function bus on clk_in;
// read data is registered and appears one cycle after the strobe.
`timescale 1ns/1ps
module eipe_regs (
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 clk_en_in,
  input  wire eipe_pkg::eipe_addr_t sfr_addr_in,
  input  wire logic                 sfr_wr_in,
  input  wire logic                 sfr_rd_in,
  input  wire eipe_pkg::eipe_data_t sfr_wdata_in,
  output eipe_pkg::eipe_data_t      sfr_rdata_out,
  output logic                      sfr_rd_hit_out,
  output logic                      timer3_irq_high_prio_out,
  output logic                      comparator1_irq_high_prio_out,
  output logic                      comparator0_irq_high_prio_out,
  output logic                      counter_array_irq_high_prio_out,
  output logic                      adc_done_irq_high_prio_out,
  output logic                      adc_window_irq_high_prio_out,
  output logic                      usb_irq_high_prio_out,
  output logic                      smbus_irq_high_prio_out,
  output logic                      uart_b_irq_enable_out,
  output logic                      vbus_level_irq_enable_out
);
  import eipe_pkg::*;

  eipe_data_t prio_q;
  eipe_data_t en_q;
  eipe_data_t rdata_r;
  eipe_data_t rdata_nxt;
  logic       rd_hit_r;
  logic       rd_hit_nxt;

  eipe_sfr_byte #(
    .ADDR (EXT_IRQ_PRIORITY_A_ADDR),
    .RST  (EXT_IRQ_PRIORITY_A_RST),
    .MASK (EXT_IRQ_PRIORITY_A_MASK)
  ) u_prio (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .addr_in    (sfr_addr_in),
    .wr_in      (sfr_wr_in),
    .wdata_in   (sfr_wdata_in),
    .q_out      (prio_q)
  );

  eipe_sfr_byte #(
    .ADDR (EXT_IRQ_ENABLE_B_ADDR),
    .RST  (EXT_IRQ_ENABLE_B_RST),
    .MASK (EXT_IRQ_ENABLE_B_MASK)
  ) u_en (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .addr_in    (sfr_addr_in),
    .wr_in      (sfr_wr_in),
    .wdata_in   (sfr_wdata_in),
    .q_out      (en_q)
  );

  // read mux; a write in the same cycle is not yet visible
  always_comb begin
    rdata_nxt  = UNMAPPED_RDATA;
    rd_hit_nxt = 1'b0;
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        EXT_IRQ_PRIORITY_A_ADDR: begin
          rdata_nxt  = prio_q;
          rd_hit_nxt = 1'b1;
        end
        EXT_IRQ_ENABLE_B_ADDR: begin
          rdata_nxt  = en_q & EXT_IRQ_ENABLE_B_MASK;
          rd_hit_nxt = 1'b1;
        end
        default: begin
          rdata_nxt  = UNMAPPED_RDATA;
          rd_hit_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_r  <= UNMAPPED_RDATA;
      rd_hit_r <= 1'b0;
    end else if (clk_en_in) begin
      rdata_r  <= rdata_nxt;
      rd_hit_r <= rd_hit_nxt;
    end
  end

  assign sfr_rdata_out  = rdata_r;
  assign sfr_rd_hit_out = rd_hit_r;

  // decoded priority levels: 1 = high, 0 = low
  assign timer3_irq_high_prio_out        = prio_q[TIMER3_PRIO_BIT];
  assign comparator1_irq_high_prio_out   = prio_q[CMP1_PRIO_BIT];
  assign comparator0_irq_high_prio_out   = prio_q[CMP0_PRIO_BIT];
  assign counter_array_irq_high_prio_out = prio_q[CNT_ARR_PRIO_BIT];
  assign adc_done_irq_high_prio_out      = prio_q[ADC_DONE_PRIO_BIT];
  assign adc_window_irq_high_prio_out    = prio_q[ADC_WIN_PRIO_BIT];
  assign usb_irq_high_prio_out           = prio_q[USB_PRIO_BIT];
  assign smbus_irq_high_prio_out         = prio_q[SMBUS_PRIO_BIT];

  // enable masks
  assign uart_b_irq_enable_out     = en_q[UART_B_EN_BIT];
  assign vbus_level_irq_enable_out = en_q[VBUS_EN_BIT];

  logic wr_prio;
  logic wr_en;
  assign wr_prio = clk_en_in && sfr_wr_in && (sfr_addr_in == EXT_IRQ_PRIORITY_A_ADDR);
  assign wr_en   = clk_en_in && sfr_wr_in && (sfr_addr_in == EXT_IRQ_ENABLE_B_ADDR);

  chk_prio_reset_low: assert property (
    @(posedge clk_in) sys_rst_in |=> (prio_q == 8'h00) && !timer3_irq_high_prio_out
      && !smbus_irq_high_prio_out)
    else $error("priority register not low after reset");

  chk_prio_write_read: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (wr_prio && !sfr_rd_in) ##1 (clk_en_in && sfr_rd_in
      && sfr_addr_in == EXT_IRQ_PRIORITY_A_ADDR && !sfr_wr_in)
      |=> sfr_rd_hit_out && (sfr_rdata_out == $past(sfr_wdata_in, 2)))
    else $error("priority readback differs from written byte");

  chk_cnt_arr_prio: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_prio |=> counter_array_irq_high_prio_out == $past(sfr_wdata_in[4]))
    else $error("counter array priority not taken from bit 4");

  chk_adc_done_prio: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_prio |=> adc_done_irq_high_prio_out == $past(sfr_wdata_in[3]))
    else $error("adc done priority not taken from bit 3");

  chk_adc_win_prio: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_prio |=> adc_window_irq_high_prio_out == $past(sfr_wdata_in[2]))
    else $error("adc window priority not taken from bit 2");

  chk_usb_prio: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_prio |=> usb_irq_high_prio_out == $past(sfr_wdata_in[1]))
    else $error("usb priority not taken from bit 1");

  chk_cmp0_prio: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_prio |=> comparator0_irq_high_prio_out == $past(sfr_wdata_in[5]))
    else $error("comparator 0 priority not taken from bit 5");

  chk_enable_unused_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_en |=> uart_b_irq_enable_out == $past(sfr_wdata_in[1])
      && vbus_level_irq_enable_out == $past(sfr_wdata_in[0]) && en_q[7:2] == 6'h00)
    else $error("enable register bits wrong after write");

  chk_other_prio_bits: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_prio |=> timer3_irq_high_prio_out == $past(sfr_wdata_in[7])
      && comparator1_irq_high_prio_out == $past(sfr_wdata_in[6])
      && smbus_irq_high_prio_out == $past(sfr_wdata_in[0]))
    else $error("timer3, comparator 1 or smbus priority bit wrong");

  chk_frozen_hold: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(prio_q) && $stable(en_q) && $stable(sfr_rdata_out))
    else $error("state changed while clock enable low");

  chk_en_reset_low: assert property (
    @(posedge clk_in) sys_rst_in |=> (en_q == 8'h00) && !uart_b_irq_enable_out
      && !vbus_level_irq_enable_out)
    else $error("enable register not low after reset");

  chk_prio_full_byte: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_prio |=> prio_q == $past(sfr_wdata_in))
    else $error("priority register did not store the full byte");

  chk_prio_no_stray: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !wr_prio |=> $stable(prio_q))
    else $error("priority register changed without a write");

  chk_en_no_stray: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !wr_en |=> $stable(en_q))
    else $error("enable register changed without a write");

  chk_prio_read_old: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && sfr_rd_in && (sfr_addr_in == EXT_IRQ_PRIORITY_A_ADDR)
      |=> sfr_rd_hit_out && (sfr_rdata_out == $past(prio_q)))
    else $error("priority read did not return the stored byte");

  chk_en_read_old: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && sfr_rd_in && (sfr_addr_in == EXT_IRQ_ENABLE_B_ADDR)
      |=> sfr_rd_hit_out && (sfr_rdata_out == {6'h00, $past(en_q[1:0])}))
    else $error("enable read did not return the stored bits");

  chk_read_idle_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && !(sfr_rd_in && ((sfr_addr_in == EXT_IRQ_PRIORITY_A_ADDR)
      || (sfr_addr_in == EXT_IRQ_ENABLE_B_ADDR)))
      |=> !sfr_rd_hit_out && (sfr_rdata_out == UNMAPPED_RDATA))
    else $error("read answer not idle without a mapped read");

endmodule

// >>> logic/eipe_pkg.sv
// eipe_pkg: addresses, field positions and reset values of the
// extended interrupt priority and enable registers.
// assumes a byte-wide special-function bus of the core.
package eipe_pkg;

  localparam int unsigned SFR_AW = 8;
  localparam int unsigned SFR_DW = 8;

  typedef logic [SFR_AW-1:0] eipe_addr_t;
  typedef logic [SFR_DW-1:0] eipe_data_t;

  // register addresses
  localparam eipe_addr_t EXT_IRQ_PRIORITY_A_ADDR = 8'hf6;
  localparam eipe_addr_t EXT_IRQ_ENABLE_B_ADDR   = 8'he7;

  // reset values
  localparam eipe_data_t EXT_IRQ_PRIORITY_A_RST = 8'h00;
  localparam eipe_data_t EXT_IRQ_ENABLE_B_RST   = 8'h00;

  // implemented bits; unused bits read as zero
  localparam eipe_data_t EXT_IRQ_PRIORITY_A_MASK = 8'hff;
  localparam eipe_data_t EXT_IRQ_ENABLE_B_MASK   = 8'h03;

  // priority field positions
  localparam int unsigned TIMER3_PRIO_BIT   = 7;
  localparam int unsigned CMP1_PRIO_BIT     = 6;
  localparam int unsigned CMP0_PRIO_BIT     = 5;
  localparam int unsigned CNT_ARR_PRIO_BIT  = 4;
  localparam int unsigned ADC_DONE_PRIO_BIT = 3;
  localparam int unsigned ADC_WIN_PRIO_BIT  = 2;
  localparam int unsigned USB_PRIO_BIT      = 1;
  localparam int unsigned SMBUS_PRIO_BIT    = 0;

  // enable field positions
  localparam int unsigned UART_B_EN_BIT     = 1;
  localparam int unsigned VBUS_EN_BIT       = 0;

  // read data for an unmapped address
  localparam eipe_data_t UNMAPPED_RDATA = 8'h00;

endpackage

// >>> logic/eipe_sfr_byte.sv
// eipe_sfr_byte: one byte-wide special-function register.
// assumes write strobe and address from the core on clk_in.
`timescale 1ns/1ps
module eipe_sfr_byte #(
  parameter eipe_pkg::eipe_addr_t ADDR = 8'h00,
  parameter eipe_pkg::eipe_data_t RST  = 8'h00,
  parameter eipe_pkg::eipe_data_t MASK = 8'hff
) (
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 clk_en_in,
  input  wire eipe_pkg::eipe_addr_t addr_in,
  input  wire logic                 wr_in,
  input  wire eipe_pkg::eipe_data_t wdata_in,
  output eipe_pkg::eipe_data_t      q_out
);
  import eipe_pkg::*;

  eipe_data_t q_r;

  // unused bits are never stored, so they always read zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q_r <= RST;
    end else if (clk_en_in && wr_in && (addr_in == ADDR)) begin
      q_r <= wdata_in & MASK;
    end
  end

  assign q_out = q_r;

endmodule

// >>> testbench/test_ext_interrupt_priority_enable.sv
// test_ext_interrupt_priority_enable: self-checking bench of eipe_regs.
// assumes eipe_pkg compiled first; the bench drives the sfr bus itself.
`timescale 1ns/1ps
module test_ext_interrupt_priority_enable;
  import eipe_pkg::*;
  typedef struct packed {
    logic       hit;
    eipe_data_t rdata;
    eipe_data_t prio;
    logic [1:0] en;
  } eipe_note_s;
  logic        clk_in       = 1'b0;
  logic        sys_rst_in   = 1'b1;
  logic        clk_en_in    = 1'b0;
  eipe_addr_t  sfr_addr_in  = 8'h00;
  logic        sfr_wr_in    = 1'b0;
  logic        sfr_rd_in    = 1'b0;
  eipe_data_t  sfr_wdata_in = 8'h00;
  eipe_data_t  sfr_rdata_out;
  logic        sfr_rd_hit_out;
  eipe_data_t  prio_seen;
  logic [1:0]  en_seen;
  eipe_data_t  prio_m       = 8'h00;
  logic [1:0]  en_m         = 2'h0;
  logic        rd_seen      = 1'b0;
  logic        idle_seen    = 1'b0;
  int unsigned seed         = 32'hb1d73794;
  int          fail_count   = 0;
  int          compares     = 0;
  int          cycles       = 0;
  eipe_note_s  notes[$];
  eipe_note_s  note;

  eipe_regs eipe_regs_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .sfr_rd_hit_out(sfr_rd_hit_out),
    .timer3_irq_high_prio_out(prio_seen[7]), .comparator1_irq_high_prio_out(prio_seen[6]),
    .comparator0_irq_high_prio_out(prio_seen[5]),
    .counter_array_irq_high_prio_out(prio_seen[4]),
    .adc_done_irq_high_prio_out(prio_seen[3]), .adc_window_irq_high_prio_out(prio_seen[2]),
    .usb_irq_high_prio_out(prio_seen[1]), .smbus_irq_high_prio_out(prio_seen[0]),
    .uart_b_irq_enable_out(en_seen[1]), .vbus_level_irq_enable_out(en_seen[0])
  );

  always #4 clk_in = ~clk_in;

  function automatic int unsigned xorshift(input int unsigned x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input eipe_data_t seen, input eipe_data_t exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one bus cycle; the note holds what the answer edge must show
  task automatic step(input eipe_addr_t a, input logic w, input logic r,
                      input eipe_data_t d, input logic e);
    eipe_note_s n;
    @(posedge clk_in);
    sfr_addr_in  <= a;
    sfr_wr_in    <= w;
    sfr_rd_in    <= r;
    sfr_wdata_in <= d;
    clk_en_in    <= e;
    n.hit   = (a == EXT_IRQ_PRIORITY_A_ADDR) || (a == EXT_IRQ_ENABLE_B_ADDR);
    n.rdata = (a == EXT_IRQ_PRIORITY_A_ADDR) ? prio_m :
              (a == EXT_IRQ_ENABLE_B_ADDR) ? {6'h00, en_m} : UNMAPPED_RDATA;
    if (e && w && a == EXT_IRQ_PRIORITY_A_ADDR) prio_m = d;
    if (e && w && a == EXT_IRQ_ENABLE_B_ADDR) en_m = d[1:0];
    n.prio = prio_m;
    n.en   = en_m;
    if (e && r) notes.push_back(n);
  endtask

  task automatic rst();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    sfr_wr_in  <= 1'b0;
    sfr_rd_in  <= 1'b0;
    clk_en_in  <= 1'b0;
    prio_m = EXT_IRQ_PRIORITY_A_RST;
    en_m   = EXT_IRQ_ENABLE_B_RST;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    rd_seen <= sfr_rd_in & clk_en_in & ~sys_rst_in;
    idle_seen <= sys_rst_in | (clk_en_in & ~sfr_rd_in);
    if (cycles > 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // answer is checked on the falling edge, half a cycle after the taking edge
  always @(negedge clk_in) begin
    if (rd_seen) begin
      if (notes.size() == 0) begin
        fail_count++;
        $display("BAD note queue empty expected note seen answer");
      end else begin
        note = notes.pop_front();
        check("rd_hit", {7'h00, sfr_rd_hit_out}, {7'h00, note.hit});
        check("rdata", sfr_rdata_out, note.rdata);
        check("prio", prio_seen, note.prio);
        check("enable", {6'h00, en_seen}, {6'h00, note.en});
      end
    end else if (idle_seen) begin
      check("idle rd_hit", {7'h00, sfr_rd_hit_out}, 8'h00);
      check("idle rdata", sfr_rdata_out, UNMAPPED_RDATA);
    end
  end

  initial begin
    int unsigned r;
    eipe_addr_t  a;
    rst();
    step(EXT_IRQ_PRIORITY_A_ADDR, 1'b0, 1'b1, 8'h00, 1'b1);
    step(EXT_IRQ_ENABLE_B_ADDR, 1'b0, 1'b1, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      step(EXT_IRQ_PRIORITY_A_ADDR, 1'b1, 1'b0, 8'h01 << i, 1'b1);
      step(EXT_IRQ_PRIORITY_A_ADDR, 1'b0, 1'b1, 8'h00, 1'b1);
    end
    step(EXT_IRQ_ENABLE_B_ADDR, 1'b1, 1'b1, 8'hff, 1'b1);
    step(EXT_IRQ_ENABLE_B_ADDR, 1'b0, 1'b1, 8'h00, 1'b1);
    repeat (400) begin
      seed = xorshift(seed);
      r = seed;
      a = r[5] ? r[31:24] : (r[4] ? EXT_IRQ_ENABLE_B_ADDR : EXT_IRQ_PRIORITY_A_ADDR);
      step(a, r[0], r[1], r[15:8], r[2] | r[3]);
    end
    rst();
    step(EXT_IRQ_PRIORITY_A_ADDR, 1'b0, 1'b1, 8'h00, 1'b1);
    step(EXT_IRQ_ENABLE_B_ADDR, 1'b0, 1'b1, 8'h00, 1'b1);
    step(8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    repeat (3) @(posedge clk_in);
    report_and_stop();
  end
endmodule
